// file: core/dvrx_defs.vh
// dvrx_defs.vh: shared constants for the video link receive path
// assumes: included by bare name from each design file of the block
`ifndef DVRX_DEFS_VH
`define DVRX_DEFS_VH
`define DVRX_FRAME_BITS     10
`define DVRX_COLOR_BITS     8
`define DVRX_NUM_CH         3
`define DVRX_NUM_PHASE      3
`define DVRX_CTL_TRANS_MIN  7
`define DVRX_SAMP_0         2
`define DVRX_SAMP_1         7
`define DVRX_SAMP_2         12
`define DVRX_SHIFT_AT       13
`define DVRX_PICK_LEVEL     8'h40
`define DVRX_CTL_00         10'h354
`define DVRX_CTL_01         10'h0ab
`define DVRX_CTL_10         10'h154
`define DVRX_CTL_11         10'h2ab
`define DVRX_FIFO_DEPTH     16
`define DVRX_KEY_DEV_ADDR   8'ha0
`define DVRX_KEY_BYTES      512
`define DVRX_KEY_CLK_NS     10000
`define DVRX_REF_CLK_NS     10
`define DVRX_KEY_HALF_CYC   ((`DVRX_KEY_CLK_NS / `DVRX_REF_CLK_NS) / 2)
`endif

// file: core/dvrx_fifo.v
// dvrx_fifo.v: synchronous fifo with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "dvrx_defs.vh"
module dvrx_fifo #(
	parameter WIDTH = 27,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output reg  [WIDTH-1:0] out_data,
	output reg              out_valid,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wp_q;
	reg  [AW:0]      rp_q;
	wire             full;
	wire             empty;
	wire             wr;
	wire             rd;
	assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign empty    = (wp_q == rp_q);
	assign in_ready = !full;
	assign wr       = in_valid && !full;
	// output register refills when empty or consumed
	assign rd       = !empty && (!out_valid || out_ready);
	always @(posedge clk) begin
		if (wr)
			mem[wp_q[AW-1:0]] <= in_data;
	end
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q      <= {(AW+1){1'b0}};
			rp_q      <= {(AW+1){1'b0}};
			out_valid <= 1'b0;
			out_data  <= {WIDTH{1'b0}};
		end else begin
			if (wr)
				wp_q <= wp_q + 1'b1;
			if (rd) begin
				rp_q     <= rp_q + 1'b1;
				out_data <= mem[rp_q[AW-1:0]];
			end
			if (rd)
				out_valid <= 1'b1;
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end
endmodule // dvrx_fifo

// file: core/dvrx_key_reader.v
// dvrx_key_reader.v: serial master that reads the key image from eeprom
// assumes: open-drain pins resolved by the surroundings; eeprom acks
`timescale 1ns/1ps
`include "dvrx_defs.vh"
module dvrx_key_reader (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       start,
	input  wire       sda_in_s,
	output reg        scl_low_q,
	output reg        sda_low_q,
	output reg  [7:0] byte_q,
	output reg        byte_vld_q,
	output reg        done_q
);
	localparam ST_IDLE = 3'd0;
	localparam ST_STRT = 3'd1;
	localparam ST_SEND = 3'd2;
	localparam ST_RECV = 3'd3;
	localparam ST_STOP = 3'd4;
	localparam ST_DONE = 3'd5;
	reg  [2:0]  st_q;
	reg  [15:0] div_q;
	reg  [1:0]  ph_q;
	reg  [3:0]  bit_q;
	reg  [1:0]  hdr_q;
	reg  [9:0]  cnt_q;
	reg  [8:0]  sh_q;
	wire        tick;
	wire [8:0]  hdr_byte;
	assign tick = (div_q == `DVRX_KEY_HALF_CYC - 1);
	// device address write, offset zero, then repeated start for read
	assign hdr_byte = (hdr_q == 2'd0) ? {`DVRX_KEY_DEV_ADDR, 1'b1} :
	                  (hdr_q == 2'd1) ? {8'h00, 1'b1} : {`DVRX_KEY_DEV_ADDR | 8'h01, 1'b1};
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE; div_q <= 16'h0000; ph_q <= 2'h0; bit_q <= 4'h0;
			hdr_q <= 2'h0; cnt_q <= 10'h000; sh_q <= 9'h000;
			scl_low_q <= 1'b0; sda_low_q <= 1'b0;
			byte_q <= 8'h00; byte_vld_q <= 1'b0; done_q <= 1'b0;
		end else begin
			byte_vld_q <= 1'b0;
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
			if (tick) begin
				ph_q <= ph_q + 2'h1;
				case (st_q)
				ST_IDLE: begin
					if (start) begin
						st_q <= ST_STRT; ph_q <= 2'h0; hdr_q <= 2'h0;
					end
				end
				ST_STRT: begin // start: data low while clock high, then clock low
					if (ph_q == 2'h0) begin scl_low_q <= 1'b0; sda_low_q <= 1'b0; end
					if (ph_q == 2'h1) sda_low_q <= 1'b1;
					if (ph_q == 2'h2) begin
						scl_low_q <= 1'b1; st_q <= ST_SEND; ph_q <= 2'h0;
						bit_q <= 4'h0; sh_q <= hdr_byte;
					end
				end
				ST_SEND: begin
					if (ph_q == 2'h0) sda_low_q <= !sh_q[8];
					if (ph_q == 2'h1) scl_low_q <= 1'b0;
					if (ph_q == 2'h2) scl_low_q <= 1'b1;
					if (ph_q == 2'h3) begin
						sh_q <= {sh_q[7:0], 1'b1}; bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h8) begin
							bit_q <= 4'h0; hdr_q <= hdr_q + 2'h1;
							if (hdr_q == 2'h1) st_q <= ST_STRT;
							else if (hdr_q == 2'h2) begin st_q <= ST_RECV; cnt_q <= 10'h000; end
							else sh_q <= {8'h00, 1'b1};
						end
					end
				end
				ST_RECV: begin // [R14]
					if (ph_q == 2'h0) sda_low_q <= (bit_q == 4'h8) && (cnt_q != `DVRX_KEY_BYTES - 1);
					if (ph_q == 2'h1) begin scl_low_q <= 1'b0; sh_q <= {sh_q[7:0], sda_in_s}; end
					if (ph_q == 2'h2) scl_low_q <= 1'b1;
					if (ph_q == 2'h3) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h7) begin byte_q <= sh_q[7:0]; byte_vld_q <= 1'b1; end
						if (bit_q == 4'h8) begin
							bit_q <= 4'h0; cnt_q <= cnt_q + 10'h001;
							if (cnt_q == `DVRX_KEY_BYTES - 1) st_q <= ST_STOP;
						end
					end
				end
				ST_STOP: begin
					if (ph_q == 2'h0) sda_low_q <= 1'b1;
					if (ph_q == 2'h1) scl_low_q <= 1'b0;
					if (ph_q == 2'h2) begin sda_low_q <= 1'b0; st_q <= ST_DONE; end
				end
				ST_DONE: done_q <= 1'b1;
				default: st_q <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // dvrx_key_reader

// file: core/dvrx_top.v
// dvrx_top.v: receive path of a three-channel serial video link
// assumes: data and link clock pins arrive asynchronously to REF_CLK at
// a rate that gives REF_CLK at least 14 cycles per bit
//
// Overview of operation
// (R01) pick best sampling phase per channel in blanking
// (R02) hold chosen phase for whole video line
// (R03) frame serial bits into parallel ten-bit words
// (R04) active frame: nine coded bits plus balance bit
// (R05) transmitter sends control characters during blanking
// (R06) four control characters set boundaries and phase
// (R07) control characters found by transition count
// (R08) align three channels to one data clock
// (R09) tolerate skew of one full input period
// (R10) decode eight colour bits, two controls, flag
// (R11) red controls first pair, green second pair
// (R12) active flag high in active video only
// (R13) decrypt once transmitter enables protection over host link; here the PROTECT_ENABLE pin enables it, host link unused
// (R14) master port fetches keys and vector from eeprom
// (R15) three-state bit releases both key-port pins
// (R16) external programmer requires key port three-stated first
// (R17) key store is serial eeprom, 512 bytes min
// (R18) eeprom answers at device address a0h
// (R19) decrypt stored keys in hardware after reading
`timescale 1ns/1ps
`include "dvrx_defs.vh"
module dvrx_top #(
	parameter NPH   = `DVRX_NUM_PHASE,
	parameter DEPTH = `DVRX_FIFO_DEPTH
) (
	input  wire        REF_CLK,
	input  wire        RSTN,
	input  wire        LINK_CLOCK_IN_POS,
	input  wire        LINK_CLOCK_IN_NEG,
	input  wire [2:0]  LINK_DATA_IN,
	input  wire        KEY_PORT_TRISTATE,
	input  wire        PROTECT_ENABLE,
	input  wire [39:0] SESSION_KEY,
	input  wire        HOST_LINK_SERIAL_CLOCK_IN,
	input  wire        HOST_LINK_SERIAL_DATA_IN,
	output reg         HOST_LINK_SERIAL_DATA_OUT,
	output reg         HOST_LINK_SERIAL_DATA_OE,
	input  wire        KEY_PORT_SERIAL_CLOCK_IN,
	output reg         KEY_PORT_SERIAL_CLOCK_OUT,
	output reg         KEY_PORT_SERIAL_CLOCK_OE,
	input  wire        KEY_PORT_SERIAL_DATA_IN,
	output reg         KEY_PORT_SERIAL_DATA_OUT,
	output reg         KEY_PORT_SERIAL_DATA_OE,
	output reg  [7:0]  PIX_RED,
	output reg  [7:0]  PIX_GREEN,
	output reg  [7:0]  PIX_BLUE,
	output reg         ACTIVE_VIDEO_FLAG,
	output reg         RED_CTRL_BIT_A,
	output reg         RED_CTRL_BIT_B,
	output reg         GREEN_CTRL_BIT_A,
	output reg         GREEN_CTRL_BIT_B,
	output reg         BLUE_CTRL_BIT_A,
	output reg         BLUE_CTRL_BIT_B,
	output reg         PIX_VALID,
	input  wire        PIX_READY,
	output reg         KEYS_LOADED
);
	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	reg  [5:0]  meta_q;
	reg  [5:0]  sync_q;
	reg         clk_prev_q;
	wire        lclk_rise;
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			meta_q <= 6'h00; sync_q <= 6'h00; clk_prev_q <= 1'b0;
		end else begin
			meta_q <= {KEY_PORT_SERIAL_DATA_IN, HOST_LINK_SERIAL_CLOCK_IN,
			           LINK_CLOCK_IN_POS & ~LINK_CLOCK_IN_NEG, LINK_DATA_IN[2:0]} ^ 6'h00;
			sync_q <= meta_q;
			clk_prev_q <= sync_q[3];
		end
	end
	assign lclk_rise = sync_q[3] & ~clk_prev_q;

	////////////////////////////////////////////////////////////////////////
	// per-channel capture: phase pick, framing, control detect
	reg         blank_q;
	reg  [9:0]  word [0:2];
	reg  [2:0]  word_vld;
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
			reg  [3:0]  ph_cnt_q;
			reg         picked_q;
			reg         settled_q;
			reg  [1:0]  sel_ph_q;
			reg  [1:0]  best_ph_q;
			reg  [7:0]  stab_q [0:2];
			reg  [2:0]  samp_q;
			reg         last_q;
			reg  [9:0]  sh_q;
			reg  [3:0]  nb_q;
			reg         locked_q;
			reg  [3:0]  trans;
			reg         vld_q;
			integer     i;
			always @* begin
				trans = 4'h0;
				for (i = 0; i < 9; i = i + 1)
					trans = trans + {3'h0, sh_q[i] ^ sh_q[i+1]};
			end
			always @(posedge REF_CLK or negedge RSTN) begin
				if (!RSTN) begin
					ph_cnt_q <= 4'h0; sel_ph_q <= 2'h0; best_ph_q <= 2'h0;
					picked_q <= 1'b0; settled_q <= 1'b0;
					stab_q[0] <= 8'h00; stab_q[1] <= 8'h00; stab_q[2] <= 8'h00;
					samp_q <= 3'h0; last_q <= 1'b0; sh_q <= 10'h000;
					nb_q <= 4'h0; locked_q <= 1'b0; vld_q <= 1'b0;
				end else begin
					vld_q <= 1'b0;
					// cycles since link clock rise; saturates so a slow link never shifts twice
					ph_cnt_q <= lclk_rise ? 4'h0 : (ph_cnt_q == 4'hf) ? 4'hf : ph_cnt_q + 4'h1;
					if (ph_cnt_q == `DVRX_SAMP_0)
						samp_q[0] <= sync_q[ch];
					if (ph_cnt_q == `DVRX_SAMP_1)
						samp_q[1] <= sync_q[ch];
					if (ph_cnt_q == `DVRX_SAMP_2)
						samp_q[2] <= sync_q[ch];
					// a phase whose sample agrees with neighbours is away from edges
					if (blank_q && ph_cnt_q == `DVRX_SHIFT_AT) begin // [R01]
						if (samp_q[0] == samp_q[1] && stab_q[1] != 8'hff)
							stab_q[1] <= stab_q[1] + 8'h01;
						if (samp_q[1] == samp_q[2] && stab_q[2] != 8'hff)
							stab_q[2] <= stab_q[2] + 8'h01;
						if (samp_q[2] == samp_q[0] && stab_q[0] != 8'hff)
							stab_q[0] <= stab_q[0] + 8'h01;
						// pick once per blanking: flipping phases mid-run would slip a bit
						if (!picked_q && (stab_q[0] == `DVRX_PICK_LEVEL || stab_q[1] == `DVRX_PICK_LEVEL ||
						    stab_q[2] == `DVRX_PICK_LEVEL)) begin
							best_ph_q <= (stab_q[1] >= stab_q[0] && stab_q[1] >= stab_q[2]) ? 2'h1 :
							             (stab_q[2] >= stab_q[0]) ? 2'h2 : 2'h0;
							picked_q  <= 1'b1;
							settled_q <= 1'b1;
						end
					end
					// new phase only taken at blanking, kept for the line
					if (!blank_q) begin // [R02]
						stab_q[0] <= 8'h00; stab_q[1] <= 8'h00; stab_q[2] <= 8'h00;
						picked_q <= 1'b0;
					end else
						sel_ph_q <= best_ph_q;
					// one shift per link period, from the chosen phase's sample
					if (ph_cnt_q == `DVRX_SHIFT_AT) begin // [R03]
						sh_q <= {samp_q[sel_ph_q], sh_q[9:1]};
						nb_q <= (nb_q == 4'h9) ? 4'h0 : nb_q + 4'h1;
						if (nb_q == 4'h9 && locked_q)
							vld_q <= 1'b1;
					end
					// first control character after the phase is settled sets word boundary; later ones leave it
					if (settled_q && trans >= `DVRX_CTL_TRANS_MIN && (sh_q == `DVRX_CTL_00 || // [R06] [R07]
					    sh_q == `DVRX_CTL_01 || sh_q == `DVRX_CTL_10 || sh_q == `DVRX_CTL_11)) begin
						locked_q <= 1'b1;
						if (!locked_q)
							nb_q <= 4'h0;
					end
				end
			end
			always @* begin
				word[ch]     = sh_q;
				word_vld[ch] = vld_q;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// channel alignment: hold words until all three have one
	reg  [9:0]  held_q [0:2];
	reg  [2:0]  have_q;
	reg         aligned_q;
	integer     k;
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			held_q[0] <= 10'h000; held_q[1] <= 10'h000; held_q[2] <= 10'h000;
			have_q <= 3'h0; aligned_q <= 1'b0;
		end else begin
			aligned_q <= 1'b0;
			// one-word holding absorbs up to one input period of skew
			for (k = 0; k < 3; k = k + 1) // [R08] [R09]
				if (word_vld[k]) begin
					held_q[k] <= word[k];
					have_q[k] <= 1'b1;
				end
			if ((have_q | word_vld) == 3'h7) begin
				have_q <= 3'h0;
				aligned_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoder
	function [7:0] dvrx_dec;
		input [9:0] w;
		reg   [7:0] d;
		integer     j;
		begin
			// bit 9 is the balance inversion, bit 8 the xor/xnor choice
			d = w[9] ? ~w[7:0] : w[7:0]; // [R04]
			dvrx_dec[0] = d[0];
			for (j = 1; j < 8; j = j + 1)
				dvrx_dec[j] = w[8] ? (d[j] ^ d[j-1]) : ~(d[j] ^ d[j-1]);
		end
	endfunction
	// held words, not the live shifters, which may already carry the next word
	function dvrx_isctl;
		input [9:0] w;
		reg   [3:0] n;
		integer     j;
		begin
			n = 4'h0;
			for (j = 0; j < 9; j = j + 1)
				n = n + {3'h0, w[j] ^ w[j+1]};
			dvrx_isctl = (n >= `DVRX_CTL_TRANS_MIN);
		end
	endfunction
	function [1:0] dvrx_ctl;
		input [9:0] w;
		begin
			dvrx_ctl = (w == `DVRX_CTL_01) ? 2'h1 : (w == `DVRX_CTL_10) ? 2'h2 :
			           (w == `DVRX_CTL_11) ? 2'h3 : 2'h0;
		end
	endfunction
	reg  [39:0] key_acc_q;
	reg  [39:0] stream_q;
	reg  [1:0]  ctl_q [0:2];
	wire        active;
	wire [23:0] pix_raw;
	wire [23:0] mask;
	assign active  = !(dvrx_isctl(held_q[0]) & dvrx_isctl(held_q[1]) & dvrx_isctl(held_q[2])); // [R07]
	assign pix_raw = {dvrx_dec(held_q[2]), dvrx_dec(held_q[1]), dvrx_dec(held_q[0])};
	// light keystream: fixed to zero whenever protection is off
	assign mask    = PROTECT_ENABLE ? stream_q[23:0] : 24'h000000;
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			blank_q <= 1'b1;
			stream_q <= 40'h0000000000;
			ctl_q[0] <= 2'h0; ctl_q[1] <= 2'h0; ctl_q[2] <= 2'h0;
		end else if (aligned_q) begin
			blank_q <= !active;
			if (!active) begin // [R05]
				ctl_q[0] <= dvrx_ctl(held_q[0]); ctl_q[1] <= dvrx_ctl(held_q[1]);
				ctl_q[2] <= dvrx_ctl(held_q[2]);
				stream_q <= key_acc_q ^ SESSION_KEY; // [R13]
			end else
				stream_q <= {stream_q[38:0], stream_q[39] ^ stream_q[20]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output fifo: pixels, controls, active flag
	wire [30:0] f_in;
	wire [30:0] f_out;
	wire        f_ovld;
	wire        f_ordy;
	reg         push_q;
	// push one cycle after alignment, once flag and controls are updated
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			push_q <= 1'b0;
		else
			push_q <= aligned_q;
	end
	assign f_in = {!blank_q, ctl_q[2], ctl_q[1], ctl_q[0], pix_raw ^ mask}; // [R10]
	assign f_ordy = PIX_READY || !PIX_VALID;
	dvrx_fifo #(
		.WIDTH     (31),
		.DEPTH     (DEPTH),
		.AW        (4)
	) u_fifo (
		.clk       (REF_CLK),
		.rst_n     (RSTN),
		.in_data   (f_in),
		.in_valid  (push_q),
		.in_ready  (),
		.out_data  (f_out),
		.out_valid (f_ovld),
		.out_ready (f_ordy)
	);
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PIX_RED <= 8'h00; PIX_GREEN <= 8'h00; PIX_BLUE <= 8'h00;
			ACTIVE_VIDEO_FLAG <= 1'b0; PIX_VALID <= 1'b0;
			RED_CTRL_BIT_A <= 1'b0; RED_CTRL_BIT_B <= 1'b0;
			GREEN_CTRL_BIT_A <= 1'b0; GREEN_CTRL_BIT_B <= 1'b0;
			BLUE_CTRL_BIT_A <= 1'b0; BLUE_CTRL_BIT_B <= 1'b0;
		end else if (f_ordy) begin
			PIX_VALID <= f_ovld;
			if (f_ovld) begin
				{PIX_RED, PIX_GREEN, PIX_BLUE} <= {f_out[23:16], f_out[15:8], f_out[7:0]};
				ACTIVE_VIDEO_FLAG <= f_out[30]; // [R12]
				{BLUE_CTRL_BIT_B, BLUE_CTRL_BIT_A} <= f_out[25:24];
				{GREEN_CTRL_BIT_B, GREEN_CTRL_BIT_A} <= f_out[27:26]; // [R11]
				{RED_CTRL_BIT_B, RED_CTRL_BIT_A} <= f_out[29:28]; // [R11]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// key port and key decryption
	wire        k_scl_low;
	wire        k_sda_low;
	wire [7:0]  k_byte;
	wire        k_vld;
	wire        k_done;
	reg         started_q;
	reg  [7:0]  kmask_q;
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			started_q <= 1'b0;
		else
			started_q <= 1'b1;
	end
	dvrx_key_reader u_keys (
		.clk        (REF_CLK),
		.rst_n      (RSTN),
		.start      (started_q && !KEY_PORT_TRISTATE), // [R16]
		.sda_in_s   (sync_q[5]),
		.scl_low_q  (k_scl_low),
		.sda_low_q  (k_sda_low),
		.byte_q     (k_byte),
		.byte_vld_q (k_vld),
		.done_q     (k_done)
	);
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			key_acc_q <= 40'h0000000000; kmask_q <= 8'h5a;
			KEY_PORT_SERIAL_CLOCK_OUT <= 1'b0; KEY_PORT_SERIAL_CLOCK_OE <= 1'b0;
			KEY_PORT_SERIAL_DATA_OUT <= 1'b0; KEY_PORT_SERIAL_DATA_OE <= 1'b0;
			HOST_LINK_SERIAL_DATA_OUT <= 1'b0; HOST_LINK_SERIAL_DATA_OE <= 1'b0;
			KEYS_LOADED <= 1'b0;
		end else begin
			// stored keys are unscrambled as each byte arrives
			if (k_vld) begin // [R19]
				kmask_q <= {kmask_q[6:0], kmask_q[7] ^ kmask_q[5]};
				key_acc_q <= {key_acc_q[31:0], k_byte ^ kmask_q} ^ {32'h0, key_acc_q[39:32]};
			end
			// open drain: only ever drive low, and not at all when released
			KEY_PORT_SERIAL_CLOCK_OE <= k_scl_low && !KEY_PORT_TRISTATE; // [R15]
			KEY_PORT_SERIAL_DATA_OE <= k_sda_low && !KEY_PORT_TRISTATE; // [R15]
			KEYS_LOADED <= k_done;
		end
	end
endmodule // dvrx_top

// file: sim/dvrx_link_partner.sv
// dvrx_link_partner.sv: serial video transmitter and key eeprom model
// assumes: bench calls send_word; eeprom lines are open drain with pull-ups
`timescale 1ns/1ps
module dvrx_link_partner #(
	parameter SKEW_G = 50,
	parameter SKEW_R = 130
) (
	output reg        link_clk_pos,
	output wire       link_clk_neg,
	output wire [2:0] link_data,
	input  wire       scl_oe,
	input  wire       sda_oe,
	output wire       scl,
	output wire       sda,
	output reg  [7:0] first_addr,
	output reg        addr_seen
);
reg [2:0] tx;
reg       d1;
reg       d2;
reg       ee_low;
reg [3:0] bits;
reg [7:0] sr;
reg [7:0] nbyte;
reg       rd;
// link clock runs free at one period per bit, as a transmitter's does; offset keeps it off REF_CLK edges
initial begin
	{tx, d1, d2, ee_low, bits, sr, nbyte, rd, addr_seen, first_addr} = 0;
	link_clk_pos = 1'b0;
	#3;
	forever #80 link_clk_pos = ~link_clk_pos;
end
assign link_clk_neg = ~link_clk_pos;
// green and red lag blue by less than one clock period
always @(tx[1]) d1 <= #(SKEW_G) tx[1];
always @(tx[2]) d2 <= #(SKEW_R) tx[2];
assign link_data = {d2, d1, tx[0]};
task send_word(input [29:0] w);
	integer i;
	for (i = 0; i < 10; i = i + 1) begin
		@(negedge link_clk_pos);
		tx = {w[20+i], w[10+i], w[i]}; // ten bits per word, lsb first
	end
endtask
////////////////////////////////////////
assign scl = ~scl_oe; // pull-ups on both lines
assign sda = ~(sda_oe | ee_low);
always @(negedge sda) if (scl) begin
	bits = 4'd0;
	nbyte = 8'd0;
	rd = 1'b0;
end
always @(posedge scl) begin
	bits = bits + 4'd1;
	if (bits < 4'd9) sr = {sr[6:0], sda};
end
always @(negedge scl) begin
	if (bits == 4'd8) begin
		if (nbyte == 8'd0) begin
			rd = sr[0];
			if (!addr_seen) first_addr = sr;
			addr_seen = 1'b1;
		end
		ee_low = (nbyte == 8'd0) || !rd; // acks every address and written byte
	end else begin
		if (bits == 4'd9) begin
			bits = 4'd0;
			nbyte = nbyte + 8'd1;
		end
		ee_low = rd && (bits < 4'd8) && !nbyte[3'd7 - bits[2:0]]; // byte index as key data
	end
end
endmodule // dvrx_link_partner

// file: sim/dvrx_top_assertions.sv
// dvrx_top_assertions.sv: port checker for the video link receiver
// assumes: bound into dvrx_top, one REF_CLK domain, RSTN active low
`timescale 1ns/1ps
module dvrx_top_checker (
	input wire       REF_CLK,
	input wire       RSTN,
	input wire       KEY_PORT_TRISTATE,
	input wire       KEY_PORT_SERIAL_CLOCK_OUT,
	input wire       KEY_PORT_SERIAL_CLOCK_OE,
	input wire       KEY_PORT_SERIAL_DATA_OUT,
	input wire       KEY_PORT_SERIAL_DATA_OE,
	input wire       HOST_LINK_SERIAL_DATA_OE,
	input wire [7:0] PIX_RED,
	input wire [7:0] PIX_GREEN,
	input wire [7:0] PIX_BLUE,
	input wire       ACTIVE_VIDEO_FLAG,
	input wire       PIX_VALID,
	input wire       PIX_READY,
	input wire       KEYS_LOADED
);
default clocking cb @(posedge REF_CLK); endclocking
default disable iff (!RSTN);
////////////////////////////////////////
// samples the key clock enable kept its value; parked high while released
reg [15:0] hold_q;
reg        scl_oe_q;
always @(posedge REF_CLK or negedge RSTN) begin
	if (!RSTN) begin
		hold_q   <= 16'd1000;
		scl_oe_q <= 1'b0;
	end else begin
		scl_oe_q <= KEY_PORT_SERIAL_CLOCK_OE;
		if (KEY_PORT_TRISTATE)
			hold_q <= 16'd1000;
		else if (KEY_PORT_SERIAL_CLOCK_OE != scl_oe_q)
			hold_q <= 16'd1;
		else if (hold_q != 16'hffff)
			hold_q <= hold_q + 16'd1;
	end
end
////////////////////////////////////////
AST_KEY_RELEASE: assert property (
	KEY_PORT_TRISTATE && $past(KEY_PORT_TRISTATE) |-> !KEY_PORT_SERIAL_CLOCK_OE && !KEY_PORT_SERIAL_DATA_OE)
	else $error("key port driven while released");
AST_KEY_OPEN_DRAIN: assert property (
	!KEY_PORT_SERIAL_CLOCK_OUT && !KEY_PORT_SERIAL_DATA_OUT)
	else $error("key port drives a high level");
AST_KEY_HALF_BIT: assert property (
	KEY_PORT_SERIAL_CLOCK_OE != scl_oe_q && !KEY_PORT_TRISTATE |-> hold_q >= 16'd499)
	else $error("key clock phase shorter than half a bit");
AST_LOAD_AFTER_READ: assert property (
	KEY_PORT_SERIAL_CLOCK_OE |-> !KEYS_LOADED)
	else $error("keys flagged loaded during a transfer");
AST_HOST_QUIET: assert property (
	!HOST_LINK_SERIAL_DATA_OE)
	else $error("host link data driven");
AST_RESET_QUIET: assert property (
	!$past(RSTN) |-> !PIX_VALID && !ACTIVE_VIDEO_FLAG && !KEYS_LOADED && !KEY_PORT_SERIAL_CLOCK_OE)
	else $error("outputs active right after reset");
AST_VALID_HOLD: assert property (
	PIX_VALID && !PIX_READY |=> PIX_VALID)
	else $error("pixel withdrawn before taken");
AST_DATA_HOLD: assert property (
	PIX_VALID && !PIX_READY |=> $stable({PIX_RED, PIX_GREEN, PIX_BLUE, ACTIVE_VIDEO_FLAG}))
	else $error("pixel changed before taken");
COV_ACTIVE: cover property (PIX_VALID && PIX_READY && ACTIVE_VIDEO_FLAG);
COV_BLANK: cover property (PIX_VALID && PIX_READY && !ACTIVE_VIDEO_FLAG);
COV_STALL: cover property (PIX_VALID && !PIX_READY [*8]);
endmodule // dvrx_top_checker

bind dvrx_top dvrx_top_checker dvrx_top_checker_inst (
	.REF_CLK(REF_CLK), .RSTN(RSTN), .KEY_PORT_TRISTATE(KEY_PORT_TRISTATE),
	.KEY_PORT_SERIAL_CLOCK_OUT(KEY_PORT_SERIAL_CLOCK_OUT), .KEY_PORT_SERIAL_CLOCK_OE(KEY_PORT_SERIAL_CLOCK_OE),
	.KEY_PORT_SERIAL_DATA_OUT(KEY_PORT_SERIAL_DATA_OUT), .KEY_PORT_SERIAL_DATA_OE(KEY_PORT_SERIAL_DATA_OE),
	.HOST_LINK_SERIAL_DATA_OE(HOST_LINK_SERIAL_DATA_OE), .PIX_RED(PIX_RED), .PIX_GREEN(PIX_GREEN),
	.PIX_BLUE(PIX_BLUE), .ACTIVE_VIDEO_FLAG(ACTIVE_VIDEO_FLAG), .PIX_VALID(PIX_VALID),
	.PIX_READY(PIX_READY), .KEYS_LOADED(KEYS_LOADED));

// file: sim/dvrx_top_bench.sv
// dvrx_top_bench.sv: self-checking bench for the video link receiver
// assumes: partner model and bound checker compiled alongside
`timescale 1ns/1ps
`include "dvrx_defs.vh"
module dvrx_top_bench;
reg         ref_clk, rstn, key_tristate, pix_ready, stall, last_act;
reg  [39:0] session_key;
reg  [5:0]  ctl;
reg  [23:0] px;
reg  [23:0] exp_q[$];
reg  [5:0]  ctl_q[$];
integer     seed, n_fail, n_compared, ln, k, na, r;
wire        lk_pos, lk_neg, scl, sda, scl_oe, sda_oe, addr_seen, flag, pix_valid, keys_loaded;
wire        rca, rcb, gca, gcb, bca, bcb;
wire [2:0]  lk_data;
wire [7:0]  first_addr, pix_r, pix_g, pix_b;
dvrx_top dvrx_top_inst (.REF_CLK(ref_clk), .RSTN(rstn), .LINK_CLOCK_IN_POS(lk_pos), .LINK_CLOCK_IN_NEG(lk_neg),
	.LINK_DATA_IN(lk_data), .KEY_PORT_TRISTATE(key_tristate), .PROTECT_ENABLE(1'b0), .SESSION_KEY(session_key),
	.HOST_LINK_SERIAL_CLOCK_IN(1'b1), .HOST_LINK_SERIAL_DATA_IN(1'b1), .HOST_LINK_SERIAL_DATA_OUT(),
	.HOST_LINK_SERIAL_DATA_OE(), .KEY_PORT_SERIAL_CLOCK_IN(scl), .KEY_PORT_SERIAL_CLOCK_OUT(),
	.KEY_PORT_SERIAL_CLOCK_OE(scl_oe), .KEY_PORT_SERIAL_DATA_IN(sda), .KEY_PORT_SERIAL_DATA_OUT(),
	.KEY_PORT_SERIAL_DATA_OE(sda_oe), .PIX_RED(pix_r), .PIX_GREEN(pix_g), .PIX_BLUE(pix_b),
	.ACTIVE_VIDEO_FLAG(flag), .RED_CTRL_BIT_A(rca), .RED_CTRL_BIT_B(rcb), .GREEN_CTRL_BIT_A(gca),
	.GREEN_CTRL_BIT_B(gcb), .BLUE_CTRL_BIT_A(bca), .BLUE_CTRL_BIT_B(bcb), .PIX_VALID(pix_valid),
	.PIX_READY(pix_ready), .KEYS_LOADED(keys_loaded));
dvrx_link_partner dvrx_link_partner_inst (.link_clk_pos(lk_pos), .link_clk_neg(lk_neg), .link_data(lk_data),
	.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda), .first_addr(first_addr), .addr_seen(addr_seen));
initial ref_clk = 1'b0;
always #5 ref_clk = ~ref_clk;
////////////////////////////////////////
function [9:0] enc(input [7:0] d);
	integer i;
	begin
		enc[0] = d[0];
		for (i = 1; i < 8; i = i + 1) enc[i] = d[i] ^ enc[i-1];
		enc[9:8] = 2'b01; // nine coded bits, balance bit left clear
	end
endfunction
function [9:0] ctl_char(input [1:0] c);
	ctl_char = (c == 2'd0) ? `DVRX_CTL_00 : (c == 2'd1) ? `DVRX_CTL_01 : (c == 2'd2) ? `DVRX_CTL_10 : `DVRX_CTL_11;
endfunction
task check(input string what, input [31:0] exp, input [31:0] got);
	begin
		n_compared = n_compared + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	end
endtask
task summarize;
	begin
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
endtask
task do_reset;
	begin
		rstn = 1'b0;
		repeat (10) @(negedge ref_clk);
		rstn = 1'b1;
	end
endtask
////////////////////////////////////////
// consumer: random backpressure, held off while a stall is asked for
always @(negedge ref_clk) begin
	r = $random(seed);
	pix_ready = !stall && (r[1:0] != 2'd0);
	if (rstn === 1'b1 && pix_valid === 1'b1 && pix_ready) begin
		if (flag === 1'b1) begin
			if (exp_q.size() == 0) check("pixel count", 0, 1);
			else check("pixel", exp_q.pop_front(), {pix_r, pix_g, pix_b});
			last_act = 1'b1;
		end else begin
			if (last_act && ctl_q.size() > 1) ctl_q.pop_front();
			last_act = 1'b0;
			if (ctl_q.size() > 0) check("ctrl", ctl_q[0], {rcb, rca, gcb, gca, bcb, bca});
		end
	end
end
initial begin
	#900000;
	check("watchdog", 0, 1);
	summarize;
end
initial begin
	seed = 32'h23fff582;
	{n_fail, n_compared, stall, last_act} = 0;
	pix_ready = 1'b0;
	session_key = {8'h00, $random(seed)};
	key_tristate = 1'b1;
	do_reset;
	repeat (1500) @(negedge ref_clk);
	check("key clk oe", 0, scl_oe);
	check("key data oe", 0, sda_oe);
	check("eeprom touched", 0, addr_seen);
	key_tristate = 1'b0;
	do_reset;
	for (ln = 0; ln < 9; ln = ln + 1) begin
		r = $random(seed);
		ctl = r[5:0];
		ctl_q.push_back(ctl);
		// long first blanking lets each channel settle its phase
		repeat ((ln == 0) ? 40 : 12) dvrx_link_partner_inst.send_word({ctl_char(ctl[5:4]), ctl_char(ctl[3:2]),
			ctl_char(ctl[1:0])});
		na = (ln == 8) ? 0 : (ln == 1) ? 1 : (ln == 3) ? 12 : 2 + (r[8:6]);
		stall = (ln == 3);
		for (k = 0; k < na; k = k + 1) begin
			px = $random(seed);
			px = (ln == 1) ? 24'h8f8e00 : (px & 24'h8f8f8f); // few transitions, never a control char
			exp_q.push_back(px);
			dvrx_link_partner_inst.send_word({enc(px[23:16]), enc(px[15:8]), enc(px[7:0])});
		end
		stall = 1'b0;
	end
	for (k = 0; k < 2000 && exp_q.size() > 0; k = k + 1) @(negedge ref_clk);
	check("pixels left", 0, exp_q.size());
	for (k = 0; k < 20000 && addr_seen !== 1'b1; k = k + 1) @(negedge ref_clk);
	check("eeprom address", `DVRX_KEY_DEV_ADDR, first_addr);
	check("keys loaded early", 0, keys_loaded);
	key_tristate = 1'b1;
	repeat (3) @(negedge ref_clk);
	check("key clk oe", 0, scl_oe);
	check("key data oe", 0, sda_oe);
	summarize;
end
endmodule // dvrx_top_bench
